// ==== verilog/fss_cmd_core.sv ====
/*
 * fss_cmd_core: serial flash command decoder for block and chip erase,
 * deep power-down, unique ID, address size, flag clear and ID reads.
 * Assumes link pins are asynchronous and slow against sys_clk_i (SCLK phases
 * of at least four system clocks); status, protection and latch inputs come
 * from logic on sys_clk_i.
 */
// What this block does
// - Opcode 52H erases 32KB with current address size; 5CH always four-byte address.
// - Opcode D8H erases 64KB with current address size; DCH always four-byte address.
// - Block and chip erase need the write-enable latch set beforehand.
// - Any address inside the block selects it; low bits ignored.
// - Erase runs only if chip select rises right after the last address bit.
// - Valid erase starts the timed cycle; busy reads 1 until it ends.
// - Write-enable latch is cleared before the erase cycle completes.
// - Block erase of a protected block is not executed.
// - 60H or C7H erase the chip only with chip select rising after eight bits.
// - Chip erase is ignored while any block is protected.
// - B9H with exact eight bits enters deep power-down after the entry delay.
// - In deep power-down only release and software reset are obeyed.
// - Power-down command while busy is rejected; running cycle continues.
// - After reset the device is in standby, not power-down.
// - 4BH returns the 128-bit unique ID after four or five dummy bytes.
// - Reset gives 24-bit addresses; B7H sets address size bit to 32-bit.
// - E9H clears address size bit, back to 24-bit addresses.
// - 30H clears error flags without the latch; refused while busy.
// - ABH releases power-down; commands resume after the plain release delay.
// - ABH plus three dummy bytes repeats the device ID until deselect.
// - ABH is ignored while busy outside deep power-down; the running cycle is untouched.
// - 90H with address 0 gives maker then part ID; address 1 swaps.
`timescale 1ns/1ps
module fss_cmd_core #(
	parameter int           BLOCK_ERASE_US = 1000,
	parameter int           ARRAY_ERASE_US = 20000,
	parameter logic [7:0]   MAKER_ID       = 8'hA5,                                // arbitrary value
	parameter logic [7:0]   PART_ID        = 8'h3C,                                // arbitrary value
	parameter logic [127:0] UNIQUE_ID      = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210 // arbitrary value
) (
	input  wire logic           sys_clk_i,
	input  wire logic           reset_i,
	input  wire logic           spi_cs_n_i,
	input  wire logic           spi_sclk_i,
	input  wire logic           spi_si_i,
	output logic                spi_so_o,
	output logic                spi_so_oe_o,
	input  wire logic           write_enable_latch_i,
	input  wire logic           protect_top_bottom_sel_i,
	input  wire logic [3:0]     protect_field_i,
	input  wire logic           other_cycle_busy_i,
	input  wire logic           soft_reset_i,
	output logic                busy_status_bit_o,
	output logic                address_size_bit_o,
	output logic                write_enable_latch_clear_o,
	output logic                error_flags_clear_o,
	output logic                erase_start_o,
	output fss_pkg::fss_erase_t erase_kind_o,
	output logic [31:0]         erase_addr_o,
	output logic                power_down_o
);
	import fss_pkg::*;

	localparam int BE_CYC = (BLOCK_ERASE_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int CE_CYC = (ARRAY_ERASE_US * NS_PER_US + CLK_NS - 1) / CLK_NS;

	logic [2:0]       pins_s;
	logic             cs_n_s;
	logic             sclk_s;
	logic             si_s;
	logic             sclk_d_r;
	logic             cs_d_r;
	logic             rise;
	logic             fall;
	logic             cs_rise;
	fss_frame_t       frame_r;
	fss_frame_t       frame_nxt;
	logic [7:0]       total_r;
	logic [7:0]       total_nxt;
	logic [7:0]       opcode_r;
	logic [7:0]       opcode_nxt;
	logic [7:0]       op_in;
	logic [31:0]      addr_r;
	logic [31:0]      addr_nxt;
	logic [UID_W-1:0] out_r;
	logic [UID_W-1:0] out_nxt;
	logic             so_nxt;
	logic             oe_nxt;
	logic             accept_op;
	fss_power_t       power_r;
	fss_power_t       power_nxt;
	logic             ads_nxt;
	logic             start_nxt;
	fss_erase_t       kind_nxt;
	logic [31:0]      eaddr_nxt;
	logic             wel_clr_nxt;
	logic             flag_clr_nxt;
	logic             exact_cmd;
	logic             exact_arg;
	logic             er_load;
	logic [31:0]      er_count;
	logic             er_busy;
	logic             pw_load;
	logic [31:0]      pw_count;
	logic             pw_done;

	// bits following the opcode before completion or data out
	function automatic logic [7:0] arg_bits(input logic [7:0] op, input logic address_size_bit);
		logic [7:0] n;
		n = 8'h00;
		case (op)
			OP_ERASE_32K, OP_ERASE_64K:     n = address_size_bit ? ADDR_LONG_BITS : ADDR_SHORT_BITS;
			OP_ERASE_32K_L, OP_ERASE_64K_L: n = ADDR_LONG_BITS;
			OP_UID:                         n = address_size_bit ? UID_DUMMY_LONG : UID_DUMMY_SHORT;
			OP_RELEASE_ID, OP_MAKER_ID:     n = ADDR_SHORT_BITS;
			default:                        n = 8'h00;
		endcase
		return n;
	endfunction

	// commands that end in a data-out phase
	function automatic logic is_read(input logic [7:0] op);
		return (op == OP_UID) || (op == OP_RELEASE_ID) || (op == OP_MAKER_ID);
	endfunction

	// data pattern rotated out MSB first for the read commands
	function automatic logic [UID_W-1:0] read_image(input logic [7:0] op, input logic a0);
		logic [UID_W-1:0] img;
		if (op == OP_UID) begin
			img = UNIQUE_ID;
		end else if (op == OP_RELEASE_ID) begin
			img = {16{PART_ID}};
		end else begin
			img = a0 ? {8{PART_ID, MAKER_ID}} : {8{MAKER_ID, PART_ID}};
		end
		return img;
	endfunction

	// top or bottom range of 64KB blocks, doubling per step of the field
	function automatic logic blk_protected(input logic [31:0] a, input logic tb, input logic [3:0] bp);
		logic [BLK_W:0] blk;
		logic [BLK_W:0] n;
		logic           hit;
		blk = {1'h0, a[BLK64_SHIFT +: BLK_W]};
		n   = '0;
		if (bp != 4'h0 && bp <= BP_ALL) begin
			n = (BLK_W+1)'(1) << (bp - 4'h1);
		end
		if (bp == 4'h0) begin
			hit = 1'h0;
		end else if (bp > BP_ALL) begin
			hit = 1'h1;
		end else begin
			hit = tb ? (blk < n) : (blk >= BLK_TOTAL - n);
		end
		return hit;
	endfunction

	// link pins into the system clock domain
	fss_sync #(
		.N         (3),
		.RESET_VAL (3'h4)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.async_i   ({spi_cs_n_i, spi_sclk_i, spi_si_i}),
		.sync_o    (pins_s)
	);

	assign cs_n_s  = pins_s[2];
	assign sclk_s  = pins_s[1];
	assign si_s    = pins_s[0];
	assign rise    = ~cs_n_s & sclk_s & ~sclk_d_r;
	assign fall    = ~cs_n_s & ~sclk_s & sclk_d_r;
	assign cs_rise = cs_n_s & ~cs_d_r;
	assign op_in   = {opcode_r[6:0], si_s};

	// opcode filter by power state and busy
	always_comb begin
		accept_op = 1'h0;
		if (power_r == PW_DOWN) begin
			accept_op = (op_in == OP_RELEASE_ID);
		end else if (power_r == PW_ON) begin
			case (op_in)
				OP_LONG_ENTER, OP_LONG_EXIT, OP_UID, OP_MAKER_ID: accept_op = 1'h1;
				OP_ERASE_32K, OP_ERASE_32K_L, OP_ERASE_64K, OP_ERASE_64K_L,
				OP_CHIP_A, OP_CHIP_B, OP_PD_ENTER, OP_FLAG_CLR, OP_RELEASE_ID:
					accept_op = ~busy_status_bit_o;
				default: accept_op = 1'h0;
			endcase
		end
	end

	// frame shifter: opcode, address or dummy bits, then data out
	always_comb begin
		frame_nxt  = frame_r;
		total_nxt  = total_r;
		opcode_nxt = opcode_r;
		addr_nxt   = addr_r;
		out_nxt    = out_r;
		so_nxt     = spi_so_o;
		oe_nxt     = spi_so_oe_o;
		if (cs_n_s) begin
			frame_nxt = FR_OPC;
			total_nxt = '0;
			addr_nxt  = '0;
			oe_nxt    = 1'h0;
		end else if (rise) begin
			total_nxt = (total_r == 8'hFF) ? total_r : total_r + 8'h01;
			unique case (frame_r)
				FR_OPC: begin
					opcode_nxt = op_in;
					if (total_r == OPC_LAST) begin
						frame_nxt = accept_op ? FR_ARG : FR_IGN;
					end
				end
				FR_ARG: begin
					addr_nxt = {addr_r[30:0], si_s};
					if (is_read(opcode_r) && total_nxt == OPC_BITS + arg_bits(opcode_r, address_size_bit_o)) begin
						frame_nxt = FR_OUT;
						out_nxt   = read_image(opcode_r, si_s);
					end
				end
				FR_OUT: begin
				end
				FR_IGN: begin
				end
			endcase
		end else if (fall && frame_r == FR_OUT) begin
			so_nxt  = out_r[UID_W-1];
			out_nxt = {out_r[UID_W-2:0], out_r[UID_W-1]};
			oe_nxt  = 1'h1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			sclk_d_r    <= 1'h0;
			cs_d_r      <= 1'h1;
			frame_r     <= FR_OPC;
			total_r     <= '0;
			opcode_r    <= '0;
			addr_r      <= '0;
			out_r       <= '0;
			spi_so_o    <= 1'h0;
			spi_so_oe_o <= 1'h0;
		end else begin
			sclk_d_r    <= sclk_s;
			cs_d_r      <= cs_n_s;
			frame_r     <= frame_nxt;
			total_r     <= total_nxt;
			opcode_r    <= opcode_nxt;
			addr_r      <= addr_nxt;
			out_r       <= out_nxt;
			spi_so_o    <= so_nxt;
			spi_so_oe_o <= oe_nxt;
		end
	end

	// command execution when chip select rises
	always_comb begin
		ads_nxt      = address_size_bit_o;
		power_nxt    = power_r;
		start_nxt    = 1'h0;
		kind_nxt     = erase_kind_o;
		eaddr_nxt    = erase_addr_o;
		wel_clr_nxt  = 1'h0;
		flag_clr_nxt = 1'h0;
		er_load      = 1'h0;
		er_count     = '0;
		pw_load      = 1'h0;
		pw_count     = '0;
		exact_cmd    = (total_r == OPC_BITS);
		exact_arg    = (total_r == OPC_BITS + arg_bits(opcode_r, address_size_bit_o));
		if (cs_rise && (frame_r == FR_ARG || frame_r == FR_OUT)) begin
			case (opcode_r)
				OP_ERASE_32K, OP_ERASE_32K_L: begin
					if (exact_arg && write_enable_latch_i &&
						!blk_protected(addr_r, protect_top_bottom_sel_i, protect_field_i)) begin
						start_nxt = 1'h1;
						kind_nxt  = ER_32K;
						eaddr_nxt = addr_r & BLK32_MASK;
						er_load   = 1'h1;
						er_count  = 32'(BE_CYC);
					end
				end
				OP_ERASE_64K, OP_ERASE_64K_L: begin
					if (exact_arg && write_enable_latch_i &&
						!blk_protected(addr_r, protect_top_bottom_sel_i, protect_field_i)) begin
						start_nxt = 1'h1;
						kind_nxt  = ER_64K;
						eaddr_nxt = addr_r & BLK64_MASK;
						er_load   = 1'h1;
						er_count  = 32'(BE_CYC);
					end
				end
				OP_CHIP_A, OP_CHIP_B: begin
					if (exact_cmd && write_enable_latch_i && protect_field_i == 4'h0) begin
						start_nxt = 1'h1;
						kind_nxt  = ER_CHIP;
						eaddr_nxt = '0;
						er_load   = 1'h1;
						er_count  = 32'(CE_CYC);
					end
				end
				OP_PD_ENTER: begin
					if (exact_cmd) begin
						power_nxt = PW_ENTER;
						pw_load   = 1'h1;
						pw_count  = 32'(PD_ENTRY_CYC);
					end
				end
				OP_LONG_ENTER: begin
					if (exact_cmd) begin
						ads_nxt = 1'h1;
					end
				end
				OP_LONG_EXIT: begin
					if (exact_cmd) begin
						ads_nxt = 1'h0;
					end
				end
				OP_FLAG_CLR: begin
					if (exact_cmd) begin
						flag_clr_nxt = 1'h1;
					end
				end
				OP_RELEASE_ID: begin
					if (power_r == PW_DOWN && frame_r == FR_ARG && exact_cmd) begin
						power_nxt = PW_WAKE;
						pw_load   = 1'h1;
						pw_count  = 32'(REL_PLAIN_CYC);
					end else if (power_r == PW_DOWN && frame_r == FR_OUT) begin
						power_nxt = PW_WAKE;
						pw_load   = 1'h1;
						pw_count  = 32'(REL_ID_CYC);
					end
				end
				default: begin
				end
			endcase
		end
		// latch cleared as the cycle starts, well before it completes
		wel_clr_nxt = start_nxt;
		if (pw_done && power_r == PW_ENTER) begin
			power_nxt = PW_DOWN;
		end else if (pw_done && power_r == PW_WAKE) begin
			power_nxt = PW_ON;
		end
		if (soft_reset_i) begin
			power_nxt = PW_ON;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			address_size_bit_o         <= 1'h0;
			power_r                    <= PW_ON;
			erase_start_o              <= 1'h0;
			erase_kind_o               <= ER_32K;
			erase_addr_o               <= '0;
			write_enable_latch_clear_o <= 1'h0;
			error_flags_clear_o        <= 1'h0;
		end else begin
			address_size_bit_o         <= ads_nxt;
			power_r                    <= power_nxt;
			erase_start_o              <= start_nxt;
			erase_kind_o               <= kind_nxt;
			erase_addr_o               <= eaddr_nxt;
			write_enable_latch_clear_o <= wel_clr_nxt;
			error_flags_clear_o        <= flag_clr_nxt;
		end
	end

	// self-timed erase cycle
	fss_timer #(
		.W (32)
	) u_erase_timer (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.load_i    (er_load),
		.count_i   (er_count),
		.busy_o    (er_busy),
		.done_o    ()
	);

	// power-down entry and release delays
	fss_timer #(
		.W (32)
	) u_power_timer (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.load_i    (pw_load),
		.count_i   (pw_count),
		.busy_o    (),
		.done_o    (pw_done)
	);

	assign busy_status_bit_o = er_busy | other_cycle_busy_i;
	assign power_down_o      = (power_r == PW_DOWN);
endmodule

// ==== verilog/fss_pkg.sv ====
/*
 * fss_pkg: opcodes, field layouts, timing figures and state types shared by
 * the serial flash erase / power / identification command decoder.
 * Assumes a 100 MHz system clock; times are in ns and turned into cycles here.
 */
package fss_pkg;

	// system clock
	localparam int CLK_NS    = 10;
	localparam int NS_PER_US = 1000;

	// opcodes decoded by this block
	localparam logic [7:0] OP_ERASE_32K   = 8'h52;
	localparam logic [7:0] OP_ERASE_32K_L = 8'h5C;
	localparam logic [7:0] OP_ERASE_64K   = 8'hD8;
	localparam logic [7:0] OP_ERASE_64K_L = 8'hDC;
	localparam logic [7:0] OP_CHIP_A      = 8'h60;
	localparam logic [7:0] OP_CHIP_B      = 8'hC7;
	localparam logic [7:0] OP_PD_ENTER    = 8'hB9;
	localparam logic [7:0] OP_UID         = 8'h4B;
	localparam logic [7:0] OP_LONG_ENTER  = 8'hB7;
	localparam logic [7:0] OP_LONG_EXIT   = 8'hE9;
	localparam logic [7:0] OP_FLAG_CLR    = 8'h30;
	localparam logic [7:0] OP_RELEASE_ID  = 8'hAB;
	localparam logic [7:0] OP_MAKER_ID    = 8'h90;

	// bit counts within a frame
	localparam logic [7:0] OPC_BITS        = 8'h08;
	localparam logic [7:0] OPC_LAST        = 8'h07;
	localparam logic [7:0] ADDR_SHORT_BITS = 8'h18;
	localparam logic [7:0] ADDR_LONG_BITS  = 8'h20;
	localparam logic [7:0] UID_DUMMY_SHORT = 8'h20;
	localparam logic [7:0] UID_DUMMY_LONG  = 8'h28;
	localparam int         UID_W           = 128;

	// array geometry and protection field
	localparam int              BLK64_SHIFT = 16;
	localparam int              BLK_W       = 9;
	localparam logic [BLK_W:0]  BLK_TOTAL   = 10'h200;
	localparam logic [3:0]      BP_ALL      = 4'h9;
	localparam logic [31:0]     BLK32_MASK  = 32'hFFFF_8000;
	localparam logic [31:0]     BLK64_MASK  = 32'hFFFF_0000;

	// power-down entry and release delays
	localparam int T_PD_ENTRY_NS    = 3000;
	localparam int T_REL_PLAIN_NS   = 8000;
	localparam int T_REL_ID_NS      = 8000;
	localparam int PD_ENTRY_CYC     = (T_PD_ENTRY_NS + CLK_NS - 1) / CLK_NS;
	localparam int REL_PLAIN_CYC    = (T_REL_PLAIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int REL_ID_CYC       = (T_REL_ID_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {FR_OPC = 2'h0, FR_ARG = 2'h1, FR_OUT = 2'h3, FR_IGN = 2'h2} fss_frame_t;
	typedef enum logic [1:0] {PW_ON = 2'h0, PW_ENTER = 2'h1, PW_DOWN = 2'h3, PW_WAKE = 2'h2} fss_power_t;
	typedef enum logic [1:0] {ER_32K = 2'h0, ER_64K = 2'h1, ER_CHIP = 2'h2} fss_erase_t;

endpackage

// ==== verilog/fss_sync.sv ====
/*
 * fss_sync: two-flop synchroniser for the serial link pins.
 * Assumes the pins are asynchronous to sys_clk_i and change slowly against it.
 */
`timescale 1ns/1ps
module fss_sync #(
	parameter int           N         = 3,
	parameter logic [N-1:0] RESET_VAL = '0
) (
	input  wire logic         sys_clk_i,
	input  wire logic         reset_i,
	input  wire logic [N-1:0] async_i,
	output logic      [N-1:0] sync_o
);
	logic [N-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			meta_r <= RESET_VAL;
			sync_o <= RESET_VAL;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule

// ==== verilog/fss_timer.sv ====
/*
 * fss_timer: loadable down counter for self-timed cycles and mode delays.
 * Assumes load_i is a one-cycle pulse from logic on the same clock.
 */
`timescale 1ns/1ps
module fss_timer #(
	parameter int W = 32
) (
	input  wire logic         sys_clk_i,
	input  wire logic         reset_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] count_i,
	output logic              busy_o,
	output logic              done_o
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         done_nxt;

	// count down, pulse done on the last step
	always_comb begin
		cnt_nxt  = cnt_r;
		done_nxt = 1'h0;
		if (load_i) begin
			cnt_nxt = count_i;
		end else if (cnt_r != '0) begin
			cnt_nxt  = cnt_r - W'(1);
			done_nxt = (cnt_r == W'(1));
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cnt_r  <= '0;
			done_o <= 1'h0;
		end else begin
			cnt_r  <= cnt_nxt;
			done_o <= done_nxt;
		end
	end

	assign busy_o = (cnt_r != '0);
endmodule

// ==== test/fss_cmd_core_properties.sv ====
/*
 * fss_cmd_core_properties: port-level assertions for the command decoder.
 * Assumes the bench holds the latch, protection and busy inputs steady across a frame.
 */
`timescale 1ns/1ps
module fss_cmd_core_properties (
	input  wire logic                sys_clk_i,
	input  wire logic                reset_i,
	input  wire logic                spi_cs_n_i,
	input  wire logic                spi_sclk_i,
	input  wire logic                spi_si_i,
	input  wire logic                spi_so_o,
	input  wire logic                spi_so_oe_o,
	input  wire logic                write_enable_latch_i,
	input  wire logic                protect_top_bottom_sel_i,
	input  wire logic [3:0]          protect_field_i,
	input  wire logic                other_cycle_busy_i,
	input  wire logic                soft_reset_i,
	input  wire logic                busy_status_bit_o,
	input  wire logic                address_size_bit_o,
	input  wire logic                write_enable_latch_clear_o,
	input  wire logic                error_flags_clear_o,
	input  wire logic                erase_start_o,
	input  wire fss_pkg::fss_erase_t erase_kind_o,
	input  wire logic [31:0]         erase_addr_o,
	input  wire logic                power_down_o
);
	import fss_pkg::*;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// steps of a frame end and of an erase cycle
	sequence s_cs_idle;
		spi_cs_n_i [*5];
	endsequence
	sequence s_busy_run;
		busy_status_bit_o [*8];
	endsequence
	property p_clear_pair;
		write_enable_latch_clear_o == erase_start_o;
	endproperty
	property p_start_wel;
		erase_start_o |-> write_enable_latch_i;
	endproperty
	property p_start_busy;
		erase_start_o |=> s_busy_run;
	endproperty
	property p_start_cs;
		erase_start_o |-> spi_cs_n_i && !power_down_o;
	endproperty
	property p_addr32;
		erase_start_o && erase_kind_o == ER_32K |-> erase_addr_o[14:0] == 15'h0000;
	endproperty
	property p_addr64;
		erase_start_o && erase_kind_o == ER_64K |-> erase_addr_o[15:0] == 16'h0000;
	endproperty
	property p_chip;
		erase_start_o && erase_kind_o == ER_CHIP |-> protect_field_i == 4'h0 && erase_addr_o == 32'h0;
	endproperty
	property p_pd_busy;
		$rose(power_down_o) |-> !busy_status_bit_o;
	endproperty
	property p_pd_quiet;
		power_down_o |-> !error_flags_clear_o && !erase_start_o;
	endproperty
	property p_flag_busy;
		error_flags_clear_o |-> !busy_status_bit_o;
	endproperty
	property p_oe_off;
		s_cs_idle |-> !spi_so_oe_o;
	endproperty
	property p_ads_frame;
		$changed(address_size_bit_o) |-> spi_cs_n_i;
	endproperty
	property p_boot;
		$fell(reset_i) |-> !power_down_o && !address_size_bit_o;
	endproperty
	a_clear_pair: assert property (p_clear_pair) else $error("latch clear apart from erase start");
	a_start_wel: assert property (p_start_wel) else $error("erase started with latch low");
	a_start_busy: assert property (p_start_busy) else $error("busy not set by erase");
	a_start_cs: assert property (p_start_cs) else $error("erase start inside a frame");
	a_addr32: assert property (p_addr32) else $error("32k base not aligned");
	a_addr64: assert property (p_addr64) else $error("64k base not aligned");
	a_chip: assert property (p_chip) else $error("chip erase while protected");
	a_pd_busy: assert property (p_pd_busy) else $error("power-down entered while busy");
	a_pd_quiet: assert property (p_pd_quiet) else $error("command obeyed in power-down");
	a_flag_busy: assert property (p_flag_busy) else $error("flag clear while busy");
	a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
	a_ads_frame: assert property (p_ads_frame) else $error("address size moved inside frame");
	a_boot: assert property (p_boot) else $error("reset left power-down or long address");
endmodule

bind fss_cmd_core fss_cmd_core_properties chk_u (.sys_clk_i, .reset_i, .spi_cs_n_i, .spi_sclk_i, .spi_si_i,
	.spi_so_o, .spi_so_oe_o, .write_enable_latch_i, .protect_top_bottom_sel_i, .protect_field_i,
	.other_cycle_busy_i, .soft_reset_i, .busy_status_bit_o, .address_size_bit_o, .write_enable_latch_clear_o,
	.error_flags_clear_o, .erase_start_o, .erase_kind_o, .erase_addr_o, .power_down_o);

// ==== test/fss_host_model.sv ====
/*
 * fss_host_model: host side of the serial link; frames one command per select.
 * Assumes a 100 MHz sampling clock; the serial clock runs at 160 ns only inside frames.
 */
`timescale 1ns/1ps
module fss_host_model (
	input  wire logic sys_clk_i,
	output logic      spi_cs_n_o,
	output logic      spi_sclk_o,
	output logic      spi_si_o,
	input  wire logic spi_so_i,
	input  wire logic spi_so_oe_i
);
	// idle: deselected, clock parked low
	initial begin
		spi_cs_n_o = 1'b1;
		spi_sclk_o = 1'b0;
		spi_si_o = 1'b0;
	end
	// n bits of tx msb first, then nrx bits read back just before each falling edge
	task automatic frame(input logic [63:0] tx, input int n, input int nrx, output logic [127:0] rx);
		rx = '0;
		@(posedge sys_clk_i) spi_cs_n_o <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		for (int i = n + nrx - 1; i >= 0; i--) begin
			@(posedge sys_clk_i) spi_sclk_o <= 1'b0;
			spi_si_o <= (i >= nrx) ? tx[i - nrx] : ~spi_si_o;
			repeat (8) @(posedge sys_clk_i);
			spi_sclk_o <= 1'b1;
			repeat (7) @(posedge sys_clk_i);
			if (i < nrx) rx = {rx[126:0], spi_so_oe_i ? spi_so_i : ~spi_so_i}; // released line reads wrong
		end
		@(posedge sys_clk_i) spi_sclk_o <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		spi_cs_n_o <= 1'b1;
		spi_si_o <= ~spi_si_o; // no stale bit on a released line
		repeat (8) @(posedge sys_clk_i);
	endtask
endmodule

// ==== test/test_fss_cmd_core.sv ====
/*
 * test_fss_cmd_core: self-checking bench for the command decoder with a host model.
 * Assumes short erase parameters (100 cycles) and the package delays.
 */
`timescale 1ns/1ps
module test_fss_cmd_core;
	import fss_pkg::*;
	localparam logic [127:0] UID = 128'hC0DE_1234_5678_9ABC_DEF0_0F1E_2D3C_4B5A; // arbitrary value
	localparam logic [7:0]   MID = 8'h5A;                                        // arbitrary value
	localparam logic [7:0]   PID = 8'hC3;                                        // arbitrary value
	logic         sys_clk_i, reset_i, write_enable_latch, sel, obusy, sreset;
	logic [3:0]   field;
	wire logic    cs_n, sclk, si, so, so_oe, busy, ads_o, wclr, fclr, start, pd;
	fss_erase_t   kind;
	logic [31:0]  eaddr, r;
	logic [127:0] rx;
	int           n_fail = 0, checked = 0, n_start = 0, n_fclr = 0;
	logic [7:0]   ops [6] = '{OP_ERASE_32K, OP_ERASE_32K_L, OP_ERASE_64K, OP_ERASE_64K_L, OP_CHIP_A, OP_CHIP_B};
	fss_cmd_core #(.BLOCK_ERASE_US(1), .ARRAY_ERASE_US(1), .MAKER_ID(MID), .PART_ID(PID), .UNIQUE_ID(UID)) dut_u (
		.sys_clk_i, .reset_i, .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_si_i(si), .spi_so_o(so),
		.spi_so_oe_o(so_oe), .write_enable_latch_i(write_enable_latch), .protect_top_bottom_sel_i(sel), .protect_field_i(field),
		.other_cycle_busy_i(obusy), .soft_reset_i(sreset), .busy_status_bit_o(busy), .address_size_bit_o(ads_o),
		.write_enable_latch_clear_o(wclr), .error_flags_clear_o(fclr), .erase_start_o(start),
		.erase_kind_o(kind), .erase_addr_o(eaddr), .power_down_o(pd));
	fss_host_model host_u (.sys_clk_i, .spi_cs_n_o(cs_n), .spi_sclk_o(sclk), .spi_si_o(si), .spi_so_i(so),
		.spi_so_oe_i(so_oe));
	// 100 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// pulse counters, sampled away from the launching edge
	always @(negedge sys_clk_i) begin
		if (start === 1'b1 && wclr === 1'b1) n_start++;
		if (fclr === 1'b1) n_fclr++;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// field n protects 2^(n-1) of 512 blocks, top or bottom
	function automatic logic prot(input logic [3:0] f, input logic s, input logic [8:0] b);
		int c;
		c = (f == 4'h0) ? 0 : (f > 4'h9) ? 512 : (1 << (f - 1));
		return s ? (int'(b) < c) : (int'(b) >= 512 - c);
	endfunction
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t ns: got %0h, want %0h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic cmd(input logic [63:0] tx, input int n, input int nrx = 0);
		host_u.frame(tx, n, nrx, rx);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		tick(90000);
		n_fail++;
		print_verdict();
	end
	// main sequence
	initial begin
		int na, nb, s0, f0, idx;
		logic go, w, s, address_size_bit;
		logic [3:0] f;
		logic [31:0] a;
		logic [63:0] tx;
		{reset_i, write_enable_latch, sel, obusy, sreset, field} = 9'h100;
		r = 32'hA999_7304;
		address_size_bit = 1'b0;
		tick(4);
		reset_i <= 1'b0;
		tick(4);
		check({pd, ads_o, busy}, 3'h0);
		// random erases over opcodes, lengths, latch, protection and address size
		for (int i = 0; i < 18; i++) begin
			r = lfsr(r);
			if (r[9]) begin
				address_size_bit = r[10];
				cmd(address_size_bit ? OP_LONG_ENTER : OP_LONG_EXIT, 8);
				check(ads_o, address_size_bit);
			end
			idx = i % 6;
			na = idx > 3 ? 0 : (idx % 2 == 1 || address_size_bit) ? 32 : 24;
			a = (na == 0) ? 32'h0 : r & (na == 32 ? 32'h01FF_FFFF : 32'h00FF_FFFF);
			r = lfsr(r);
			f = r[4] ? 4'h0 : r[3:0];
			s = r[5];
			w = r[6] | r[7];
			{field, sel, write_enable_latch} <= {f, s, w};
			nb = 8 + na + (r[12:11] == 2'h2 ? -1 : r[12:11] == 2'h3 ? 8 : 0);
			tx = (64'(ops[idx]) << na) | 64'(a);
			if (nb < na + 8) tx = tx >> 1;
			if (nb > na + 8) tx = (tx << 8) | 64'(r[31:24]);
			go = w && nb == na + 8 && (na == 0 ? f == 4'h0 : !prot(f, s, a[24:16]));
			s0 = n_start;
			cmd(tx, nb);
			check(n_start - s0, go);
			if (go) begin
				check(kind, idx > 3 ? ER_CHIP : idx < 2 ? ER_32K : ER_64K);
				check(eaddr, a & (idx < 2 ? BLK32_MASK : BLK64_MASK));
				check(busy, 1'b1);
				for (int k = 0; k < 200 && busy !== 1'b0; k++) tick(1);
				check(busy, 1'b0);
			end
		end
		$display("done: erases");
		// refusals while another cycle keeps the device busy, then flag clear once idle
		{obusy, write_enable_latch, field} <= 6'h30;
		s0 = n_start;
		f0 = n_fclr;
		cmd(OP_FLAG_CLR, 8);
		cmd(OP_CHIP_A, 8);
		cmd(OP_PD_ENTER, 8);
		cmd({OP_RELEASE_ID, 24'h0}, 32, 8);
		check(rx[7:0] == PID, 1'b0);
		tick(PD_ENTRY_CYC + 10);
		check(pd, 1'b0);
		check(n_start - s0 + n_fclr - f0, 0);
		{obusy, write_enable_latch} <= 2'h0;
		cmd(OP_FLAG_CLR << 1, 9);
		cmd(OP_FLAG_CLR, 8);
		check(n_fclr - f0, 1);
		$display("done: busy and flags");
		// power-down entry, commands inside it, release and soft reset
		cmd(OP_PD_ENTER << 1, 9);
		tick(PD_ENTRY_CYC + 10);
		check(pd, 1'b0);
		cmd(OP_PD_ENTER, 8);
		check(pd, 1'b0);
		tick(PD_ENTRY_CYC);
		check(pd, 1'b1);
		write_enable_latch <= 1'b1;
		s0 = n_start;
		f0 = n_fclr;
		cmd(address_size_bit ? OP_LONG_EXIT : OP_LONG_ENTER, 8);
		check(ads_o, address_size_bit);
		cmd(OP_CHIP_B, 8);
		cmd(OP_FLAG_CLR, 8);
		check(n_start - s0 + n_fclr - f0, 0);
		cmd(OP_RELEASE_ID, 8);
		check(pd, 1'b0);
		cmd(OP_FLAG_CLR, 8);
		check(n_fclr - f0, 0);
		tick(REL_PLAIN_CYC);
		cmd(OP_FLAG_CLR, 8);
		check(n_fclr - f0, 1);
		cmd(OP_PD_ENTER, 8);
		tick(PD_ENTRY_CYC);
		check(pd, 1'b1);
		sreset <= 1'b1;
		tick(1);
		{sreset, write_enable_latch} <= 2'h0;
		tick(4);
		check(pd, 1'b0);
		$display("done: power-down");
		// identification reads in both address sizes
		cmd({OP_RELEASE_ID, 24'h0}, 32, 16);
		check(rx[15:0], {PID, PID});
		for (int j = 0; j < 2; j++) begin
			cmd(j ? OP_LONG_ENTER : OP_LONG_EXIT, 8);
			cmd({OP_MAKER_ID, 23'h0, j[0]}, 32, 16);
			check(rx[15:0], j ? {PID, MID} : {MID, PID});
			cmd(64'(OP_UID) << (32 + 8 * j), 40 + 8 * j, 128);
			check(rx, UID);
		end
		$display("done: identification");
		print_verdict();
	end
endmodule
